// ===== logic/mts_sequencer.sv
/*
 Manual transfer sequencer: source watch, delays, manual wait and
 contactor command, with a classic Wishbone register slave.
 Assumes source-ok and command pins are asynchronous, command and
 selector pins are active low (grounded = asserted).
*/
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
module mts_sequencer #(
    parameter bit          HAS_TO_EMERG = 1'b1,
    parameter bit          HAS_SELECTOR = 1'b1,
    parameter int unsigned SEC_CYCLES   = mts_pkg::SEC_CYC,
    parameter int unsigned DEB_CYCLES   = mts_pkg::DEBOUNCE_CYC,
    parameter int unsigned FLASH_CYCLES = mts_pkg::FLASH_CYC,
    parameter int unsigned BRIEF_CYCLES = mts_pkg::BRIEF_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    // Source sensing and operator terminals
    input  wire logic        normal_source_ok,
    input  wire logic        emergency_source_ok,
    input  wire logic        to_emergency_cmd_terminal_n,
    input  wire logic        to_normal_cmd_terminal_n,
    input  wire logic        manual_select_terminal_n,
    // Engine and contactor
    output logic             engine_start,
    output logic             contactor_to_emergency,
    // Indicators
    output logic             led_normal_avail,
    output logic             led_emerg_avail,
    output logic             led_start_dly_run,
    output logic             led_start_dly_done,
    output logic             led_retx_dly_run,
    output logic             led_retx_dly_done,
    output logic             led_cool_dly_run,
    output logic             led_cool_dly_done,
    output logic             led_system_alert,
    output logic             led_not_in_auto,
    output logic             led_pos_normal,
    output logic             led_pos_emerg,
    output logic             manual_transfer_msg
);
    import mts_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State record

    typedef struct packed {
        mts_state_t      st;
        logic            eng;
        logic            cont_em;
        logic            pend;
        logic [15:0]     start_dly;
        logic [15:0]     retx_dly;
        logic [15:0]     cool_dly;
        logic            flash_en;
        logic [31:0]     flash_cnt;
        logic            flash;
        logic [31:0]     brief_cnt;
        logic [IN_N-1:0] prev;
        logic            ack;
        logic [31:0]     rdat;
        logic            l_navail;
        logic            l_eavail;
        logic            l_sd_run;
        logic            l_sd_done;
        logic            l_rt_run;
        logic            l_rt_done;
        logic            l_cd_run;
        logic            l_cd_done;
        logic            l_alert;
        logic            l_nauto;
        logic            msg;
    } mts_core_st_t;

    localparam mts_core_st_t S_RST = '{
        st: ST_NORMAL, start_dly: START_RST, retx_dly: RETX_RST,
        cool_dly: COOL_RST, flash_en: 1'b1, prev: '1, default: '0
    };

    mts_core_st_t    s_q, s_d;
    logic [IN_N-1:0] lvl;
    logic            tmr_start;
    logic [15:0]     tmr_secs;
    logic            tmr_done;

    if (FLASH_CYCLES < 1 || BRIEF_CYCLES < 1) begin : g_chk
        $error("mts_sequencer: FLASH_CYCLES and BRIEF_CYCLES must be >= 1");
    end

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge for the 16-bit delay registers
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = dat[7:0];
        if (sel[1]) r[15:8] = dat[15:8];
        return r;
    endfunction

    // Delay states whose entry starts the timer
    function automatic logic is_dly(input mts_state_t s);
        return s == ST_START_DLY || s == ST_RETX_DLY || s == ST_COOLDOWN;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Input conditioning and timer

    // Sources are filtered too, so a flickering source cannot bounce the FSM
    mts_debounce #(
        .WIDTH  (IN_N),
        .CYCLES (DEB_CYCLES)
    ) u_deb (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   ({manual_select_terminal_n, to_normal_cmd_terminal_n,
                 to_emergency_cmd_terminal_n, emergency_source_ok,
                 normal_source_ok}),
        .level (lvl)
    );

    mts_delay_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tmr (
        .mclk  (mclk),
        .rst_b (rst_b),
        .start (tmr_start),
        .secs  (tmr_secs),
        .busy  (),
        .done  (tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic nok;
        logic eok;
        logic manual;
        logic p_em;
        logic p_no;
        logic bus;
        nok = lvl[IN_NOK];
        eok = lvl[IN_EOK];
        // Grounded selector means manual; without a selector always manual
        manual = HAS_SELECTOR ? ~lvl[IN_MAN] : 1'b1;
        // One press gives one pulse: low level on a high-to-low edge
        p_em = HAS_TO_EMERG && !lvl[IN_TOEM] && s_q.prev[IN_TOEM];
        p_no = !lvl[IN_TONO] && s_q.prev[IN_TONO];
        bus = wb_cyc_i && wb_stb_i && !s_q.ack;

        s_d = s_q;
        s_d.prev = lvl;
        s_d.ack = bus;

        // Register access; unmapped offsets ack and read zero
        if (bus) begin
            s_d.rdat = '0;
            case (wb_adr_i)
                ADR_CTRL: begin
                    s_d.rdat[CTRL_FLASH] = s_q.flash_en;
                    if (wb_we_i && wb_sel_i[0]) s_d.flash_en = wb_dat_i[CTRL_FLASH];
                end
                ADR_START: begin
                    s_d.rdat[15:0] = s_q.start_dly;
                    if (wb_we_i) s_d.start_dly = wr16(s_q.start_dly, wb_dat_i, wb_sel_i);
                end
                ADR_RETX: begin
                    s_d.rdat[15:0] = s_q.retx_dly;
                    if (wb_we_i) s_d.retx_dly = wr16(s_q.retx_dly, wb_dat_i, wb_sel_i);
                end
                ADR_COOL: begin
                    s_d.rdat[15:0] = s_q.cool_dly;
                    if (wb_we_i) s_d.cool_dly = wr16(s_q.cool_dly, wb_dat_i, wb_sel_i);
                end
                ADR_STATUS: begin
                    s_d.rdat[3:0] = s_q.st;
                    s_d.rdat[STS_CONT] = s_q.cont_em;
                    s_d.rdat[STS_ENG] = s_q.eng;
                    s_d.rdat[STS_MAN] = manual;
                    s_d.rdat[STS_NOK] = nok;
                    s_d.rdat[STS_EOK] = eok;
                end
                default: ;
            endcase
        end

        // Free-running flash, rate fixed at build time
        if (s_q.flash_cnt == 32'(FLASH_CYCLES - 1)) begin
            s_d.flash_cnt = '0;
            s_d.flash = ~s_q.flash;
        end else begin
            s_d.flash_cnt = s_q.flash_cnt + 32'h1;
        end

        // Sequencer
        case (s_q.st)
            ST_NORMAL: begin
                if (!nok) begin
                    s_d.st = ST_START_DLY;
                end else if (manual && p_em) begin
                    // Operator start: run engine, transfer once it is up
                    s_d.eng = 1'b1;
                    s_d.pend = 1'b1;
                    s_d.st = ST_WAIT_SRC;
                end
            end
            ST_START_DLY: begin
                if (nok) begin
                    s_d.st = ST_NORMAL;
                end else if (tmr_done) begin
                    s_d.eng = 1'b1;
                    s_d.st = ST_WAIT_SRC;
                end
            end
            ST_WAIT_SRC: begin
                if (eok) begin
                    if (manual && HAS_TO_EMERG && !s_q.pend) begin
                        s_d.st = ST_WAIT_TO_EM;
                    end else begin
                        // No manual hold for this build or mode, or after an operator start
                        s_d.cont_em = 1'b1;
                        s_d.pend = 1'b0;
                        s_d.st = ST_ON_EMERG;
                    end
                end else if (nok && !s_q.pend) begin
                    s_d.st = ST_COOLDOWN;
                end
            end
            ST_WAIT_TO_EM: begin
                if (p_em || !manual) begin
                    s_d.cont_em = 1'b1;
                    s_d.st = ST_ON_EMERG;
                end else if (!eok) begin
                    s_d.st = ST_WAIT_SRC;
                end else if (nok) begin
                    s_d.st = ST_COOLDOWN;
                end
            end
            ST_ON_EMERG: begin
                if (nok) begin
                    s_d.st = ST_RETX_DLY;
                end
            end
            ST_RETX_DLY: begin
                if (!nok) begin
                    s_d.st = ST_ON_EMERG;
                end else if (!eok) begin
                    // Connected emergency lost: go back at once
                    s_d.cont_em = 1'b0;
                    s_d.st = ST_COOLDOWN;
                end else if (tmr_done) begin
                    if (manual) begin
                        s_d.st = ST_WAIT_TO_NO;
                    end else begin
                        s_d.cont_em = 1'b0;
                        s_d.st = ST_COOLDOWN;
                    end
                end
            end
            ST_WAIT_TO_NO: begin
                if (!nok) begin
                    s_d.st = ST_ON_EMERG;
                end else if (p_no || !eok || !manual) begin
                    s_d.cont_em = 1'b0;
                    s_d.st = ST_COOLDOWN;
                end
            end
            ST_COOLDOWN: begin
                if (!nok) begin
                    s_d.st = ST_WAIT_SRC;
                end else if (tmr_done) begin
                    s_d.eng = 1'b0;
                    s_d.brief_cnt = '0;
                    s_d.st = ST_COOL_DONE;
                end
            end
            ST_COOL_DONE: begin
                // Done lamp held only long enough to be seen
                if (s_q.brief_cnt == 32'(BRIEF_CYCLES - 1)) begin
                    s_d.st = ST_NORMAL;
                end else begin
                    s_d.brief_cnt = s_q.brief_cnt + 32'h1;
                end
            end
            default: begin
                s_d.st = ST_NORMAL;
            end
        endcase

        // Timer loads on entry to any delay state
        tmr_start = is_dly(s_d.st) && (s_d.st != s_q.st);
        case (s_d.st)
            ST_START_DLY: tmr_secs = s_q.start_dly;
            ST_RETX_DLY:  tmr_secs = s_q.retx_dly;
            default:      tmr_secs = s_q.cool_dly;
        endcase

        // Indicators registered from the next state and the filtered source and selector levels
        s_d.l_navail = nok;
        s_d.l_eavail = eok && (s_d.eng || s_d.st == ST_COOL_DONE);
        s_d.l_sd_run = s_d.st == ST_START_DLY;
        s_d.l_sd_done = s_d.st == ST_WAIT_SRC || s_d.st == ST_WAIT_TO_EM;
        s_d.l_rt_run = s_d.st == ST_RETX_DLY;
        s_d.l_rt_done = s_d.st == ST_WAIT_TO_NO;
        s_d.l_cd_run = s_d.st == ST_COOLDOWN;
        s_d.l_cd_done = s_d.st == ST_COOL_DONE;
        s_d.l_nauto = manual;
        // Waiting states are only reached in manual mode
        s_d.msg = s_d.st == ST_WAIT_TO_EM || s_d.st == ST_WAIT_TO_NO;
        s_d.l_alert = s_d.msg && (s_d.flash || !s_d.flash_en);
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_ack_o               = s_q.ack;
    assign wb_dat_o               = s_q.rdat;
    assign engine_start           = s_q.eng;
    assign contactor_to_emergency = s_q.cont_em;
    assign led_normal_avail       = s_q.l_navail;
    assign led_emerg_avail        = s_q.l_eavail;
    assign led_start_dly_run      = s_q.l_sd_run;
    assign led_start_dly_done     = s_q.l_sd_done;
    assign led_retx_dly_run       = s_q.l_rt_run;
    assign led_retx_dly_done      = s_q.l_rt_done;
    assign led_cool_dly_run       = s_q.l_cd_run;
    assign led_cool_dly_done      = s_q.l_cd_done;
    assign led_system_alert       = s_q.l_alert;
    assign led_not_in_auto        = s_q.l_nauto;
    // Position lamps follow the command; no auxiliary contact is wired in
    assign led_pos_normal         = ~s_q.cont_em;
    assign led_pos_emerg          = s_q.cont_em;
    assign manual_transfer_msg    = s_q.msg;
endmodule // mts_sequencer

// ===== logic/mts_pkg.sv
/*
 Constants and types shared by the manual transfer sequencer files.
 Assumes a 50 MHz mclk and a classic Wishbone slave port, 32-bit data.
*/
// Overview of operation
// - If the connected emergency source fails, transfer back to normal even in manual mode.
// - In manual mode, normal failure turns the normal-available lamp off.
// - Start-delay lamp lit while timing; start-done lamp lit once engine start is given.
// - Emergency-available lamp lit once emergency appears after engine start.
// - Manual, emergency up, delays done: flash alert, show message, hold contactor.
// - To-emergency command moves contactor to emergency and swaps position lamps.
// - Normal return lights normal lamp, then retransfer running and done lamps.
// - Manual, retransfer done: flash alert, show message, wait for to-normal command.
// - To-normal command moves the contactor to the normal position.
// - After retransfer, cooldown lamp lit while engine cooldown delay counts.
// - Cooldown end stops engine, shows done lamp briefly, then clears emergency lamp.
// - Not-in-automatic lamp follows the manual position of the selector.
// - Manual wait with all delays done lights alert and shows the message.
// - A to-emergency command starts and runs the generator engine.
// - To-emergency input is active when grounded; acts as the pushbutton does.
// - To-normal input is active when grounded and transfers to normal while waiting.
// - Manual selector input is asserted when grounded and enables alert and message.
// - Build options: commands both ways or to-normal only, selector fitted or not.

package mts_pkg;
    // Timing, all derived from the clock rate
    localparam int unsigned CLK_MHZ     = 50;
    localparam int unsigned SEC_US      = 1000000;
    localparam int unsigned SEC_CYC     = SEC_US * CLK_MHZ;
    localparam int unsigned DEBOUNCE_US = 20000;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int unsigned FLASH_US    = 250000;
    localparam int unsigned FLASH_CYC   = FLASH_US * CLK_MHZ;
    localparam int unsigned BRIEF_US    = 1000000;
    localparam int unsigned BRIEF_CYC   = BRIEF_US * CLK_MHZ;

    // Register byte offsets
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_START  = 8'h04;
    localparam logic [7:0] ADR_RETX   = 8'h08;
    localparam logic [7:0] ADR_COOL   = 8'h0C;
    localparam logic [7:0] ADR_STATUS = 8'h10;

    // Register fields and reset values
    localparam int unsigned CTRL_FLASH = 0;
    localparam logic [15:0] START_RST  = 16'h0003;
    localparam logic [15:0] RETX_RST   = 16'h012C;
    localparam logic [15:0] COOL_RST   = 16'h012C;
    localparam int unsigned STS_CONT   = 4;
    localparam int unsigned STS_ENG    = 5;
    localparam int unsigned STS_MAN    = 6;
    localparam int unsigned STS_NOK    = 7;
    localparam int unsigned STS_EOK    = 8;

    // Input bundle positions
    localparam int unsigned IN_NOK  = 0;
    localparam int unsigned IN_EOK  = 1;
    localparam int unsigned IN_TOEM = 2;
    localparam int unsigned IN_TONO = 3;
    localparam int unsigned IN_MAN  = 4;
    localparam int unsigned IN_N    = 5;

    typedef enum logic [3:0] {
        ST_NORMAL, ST_START_DLY, ST_WAIT_SRC, ST_WAIT_TO_EM, ST_ON_EMERG,
        ST_RETX_DLY, ST_WAIT_TO_NO, ST_COOLDOWN, ST_COOL_DONE
    } mts_state_t;
endpackage

// ===== logic/mts_debounce.sv
/*
 Two-stage synchroniser and debounce filter for a bundle of pin inputs.
 Assumes the pins are asynchronous to mclk; output changes only after
 an input has held a new level for CYCLES clocks.
*/
`timescale 1ns/10ps
module mts_debounce #(
    parameter int unsigned WIDTH  = 5,
    parameter int unsigned CYCLES = 1000000
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Raw pins and filtered levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    import mts_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0]       s1;
        logic [WIDTH-1:0]       s2;
        logic [WIDTH-1:0]       lvl;
        logic [WIDTH-1:0][31:0] cnt;
    } mts_deb_st_t;

    mts_deb_st_t s_q, s_d;

    if (CYCLES < 1) begin : g_chk
        $error("mts_debounce: CYCLES must be at least 1");
    end

    // First stage feeds only the second; filter reads s2
    always_comb begin
        s_d = s_q;
        s_d.s1 = pin;
        s_d.s2 = s_q.s1;
        for (int i = 0; i < WIDTH; i++) begin
            if (s_q.s2[i] == s_q.lvl[i]) begin
                s_d.cnt[i] = '0;
            end else if (s_q.cnt[i] == 32'(CYCLES - 1)) begin
                s_d.cnt[i] = '0;
                s_d.lvl[i] = s_q.s2[i];
            end else begin
                s_d.cnt[i] = s_q.cnt[i] + 32'h1;
            end
        end
    end

    // Pins idle high (open contact) so reset assumes that level
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{s1: '1, s2: '1, lvl: '1, cnt: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;
endmodule // mts_debounce

// ===== logic/mts_delay_timer.sv
/*
 Seconds delay timer: load a count of seconds, pulse done at expiry.
 Assumes start is a one-cycle pulse from the sequencer on mclk.
*/
`timescale 1ns/10ps
module mts_delay_timer #(
    parameter int unsigned SEC_CYCLES = 50000000
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Control
    input  wire logic        start,
    input  wire logic [15:0] secs,
    // Status
    output logic             busy,
    output logic             done
);
    import mts_pkg::*;

    typedef struct packed {
        logic [31:0] sub;
        logic [15:0] sec;
        logic        busy;
        logic        done;
    } mts_tmr_st_t;

    mts_tmr_st_t s_q, s_d;

    if (SEC_CYCLES < 1) begin : g_chk
        $error("mts_delay_timer: SEC_CYCLES must be at least 1");
    end

    // Restart wins over a running count
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d = '{sub: '0, sec: secs, busy: 1'b1, done: 1'b0};
        end else if (s_q.busy) begin
            if (s_q.sec == 16'h0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else if (s_q.sub == 32'(SEC_CYCLES - 1)) begin
                s_d.sub = '0;
                s_d.sec = s_q.sec - 16'h1;
            end else begin
                s_d.sub = s_q.sub + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule // mts_delay_timer

// ===== verif/mts_operator.sv
/* Operator panel model: momentary buttons and selector key.
   Assumes one-cycle go pulses from the bench, on mclk. */
`timescale 1ns/10ps
module mts_operator #(
    parameter int HOLD = 12
) (
    // Clock and bench requests
    input  wire logic mclk,
    input  wire logic go_em,
    input  wire logic go_no,
    input  wire logic manual,
    // Grounded-contact terminals
    output logic      to_em_n,
    output logic      to_no_n,
    output logic      man_n
);
    int em_q = 0;
    int no_q = 0;
    // Contact closes long enough to pass the filter, then opens again
    always_ff @(posedge mclk) begin
        em_q <= go_em ? HOLD : (em_q > 0 ? em_q - 1 : 0);
        no_q <= go_no ? HOLD : (no_q > 0 ? no_q - 1 : 0);
    end
    // Open contact floats to the pull-up level
    assign to_em_n = !(em_q > 0);
    assign to_no_n = !(no_q > 0);
    assign man_n   = !manual;
endmodule // mts_operator

// ===== verif/mts_sequencer_checker.sv
/* Port checker for the sequencer.
   Assumes it is bound onto mts_sequencer, single clock domain. */
`timescale 1ns/10ps
module mts_sequencer_checker (
    // Clock, reset and bus
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Selector, engine, contactor and lamps
    input wire logic manual_select_terminal_n,
    input wire logic engine_start,
    input wire logic contactor_to_emergency,
    input wire logic led_normal_avail,
    input wire logic led_emerg_avail,
    input wire logic led_start_dly_done,
    input wire logic led_cool_dly_done,
    input wire logic led_not_in_auto,
    input wire logic led_pos_normal,
    input wire logic led_pos_emerg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_pos; led_pos_emerg == contactor_to_emergency && led_pos_normal != led_pos_emerg
        && (!led_pos_emerg || engine_start);
    endproperty
    a_pos: assert property (p_pos) else $error("position lamps wrong");
    property p_nia; $rose(led_not_in_auto) |-> !manual_select_terminal_n; endproperty
    a_nia: assert property (p_nia) else $error("manual lamp without selector");
    property p_cem; $rose(contactor_to_emergency) |-> led_emerg_avail; endproperty
    a_cem: assert property (p_cem) else $error("transfer to dead source");
    property p_cno; $fell(contactor_to_emergency) |-> led_normal_avail; endproperty
    a_cno: assert property (p_cno) else $error("return to dead source");
    property p_cdone; led_cool_dly_done |-> !engine_start; endproperty
    a_cdone: assert property (p_cdone) else $error("engine runs at cooldown end");
    property p_sdone; $rose(led_start_dly_done) |-> engine_start; endproperty
    a_sdone: assert property (p_sdone) else $error("start lamp without engine");
endmodule // mts_sequencer_checker

bind mts_sequencer mts_sequencer_checker mts_sequencer_checker_inst (
    .mclk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .manual_select_terminal_n,
    .engine_start, .contactor_to_emergency, .led_normal_avail, .led_emerg_avail,
    .led_start_dly_done, .led_cool_dly_done, .led_not_in_auto, .led_pos_normal,
    .led_pos_emerg);

// ===== verif/testbench.sv
/* Self-checking bench: register access and a manual transfer round trip.
   Assumes short timing parameters so the run stays brief. */
`timescale 1ns/10ps
module testbench;
    import mts_pkg::*;
    logic        mclk, rst_b, we, cyc, stb, nok, eok, go_em, go_no, man, ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    wire  logic  tem_n, tno_n, man_n;
    wire  logic [14:0] o;
    int          miscompares = 0;
    int          compares = 0;
    logic [7:0]  ra [5] = '{ADR_CTRL, ADR_START, ADR_RETX, ADR_COOL, 8'h14};
    logic [31:0] rv [5] = '{32'h1, {16'h0, START_RST}, {16'h0, RETX_RST}, {16'h0, COOL_RST},
                            32'h0};
    mts_sequencer #(.SEC_CYCLES(10), .DEB_CYCLES(4), .FLASH_CYCLES(3), .BRIEF_CYCLES(5))
    mts_sequencer_inst (.mclk, .rst_b, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .normal_source_ok(nok), .emergency_source_ok(eok),
        .to_emergency_cmd_terminal_n(tem_n), .to_normal_cmd_terminal_n(tno_n),
        .manual_select_terminal_n(man_n), .engine_start(o[0]),
        .contactor_to_emergency(o[1]), .led_normal_avail(o[2]), .led_emerg_avail(o[3]),
        .led_start_dly_run(o[4]), .led_start_dly_done(o[5]), .led_retx_dly_run(o[6]),
        .led_retx_dly_done(o[7]), .led_cool_dly_run(o[8]), .led_cool_dly_done(o[9]),
        .led_system_alert(o[10]), .led_not_in_auto(o[11]), .led_pos_normal(o[12]),
        .led_pos_emerg(o[13]), .manual_transfer_msg(o[14]));
    mts_operator mts_operator_inst (.mclk, .go_em, .go_no, .manual(man), .to_em_n(tem_n),
        .to_no_n(tno_n), .man_n(man_n));
    ////////////////////////////////////////////////////////////////
    // Verdict, comparison and bounded waits
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wt(input int i, input logic v);
        int n;
        n = 0;
        while (o[i] !== v && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk($sformatf("out%0d", i), {31'h0, v}, {31'h0, o[i]});
        if (n == 2000) end_sim();
    endtask
    // Classic single Wishbone cycle; data taken while ack stands
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        sel <= w ? 4'h3 : 4'hF;
        do @(posedge mclk); while (ack !== 1'b1 && ++n < 50);
        rd = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge mclk);
        if (n >= 50) chk("ack", 1, 0);
        if (n >= 50) end_sim();
    endtask
    task automatic press(input logic em);
        if (em) go_em <= 1'b1;
        else go_no <= 1'b1;
        @(posedge mclk);
        {go_em, go_no} <= 2'b00;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {cyc, stb, we, go_em, go_no, man, eok, rst_b} = '0;
        {adr, sel, wdat, nok} = {8'h0, 4'h0, 32'h0, 1'b1};
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        foreach (ra[i]) begin
            wb(0, ra[i], 0);
            chk("reset value", rv[i], rd);
        end
        for (int i = 1; i < 4; i++) begin
            wb(1, ra[i], 32'hFFFF_0001);
            wb(0, ra[i], 0);
            chk("delay reg", 32'h1, rd);
        end
        $display("test registers done");
        man <= 1'b1;
        wt(11, 1);
        nok <= 1'b0;
        wt(2, 0);
        wt(4, 1);
        wt(0, 1);
        chk("start done", 1, o[5]);
        eok <= 1'b1;
        wt(3, 1);
        wt(14, 1);
        wt(10, 1);
        chk("held", 0, o[1]);
        press(1);
        wt(13, 1);
        chk("pos normal", 0, o[12]);
        nok <= 1'b1;
        wt(2, 1);
        wt(6, 1);
        wt(7, 1);
        wt(14, 1);
        wb(0, ADR_STATUS, 0);
        chk("status", 32'(ST_WAIT_TO_NO) | (32'h1F << STS_CONT), rd);
        press(0);
        wt(1, 0);
        wt(8, 1);
        wt(9, 1);
        chk("engine", 0, o[0]);
        wt(3, 0);
        $display("test manual round trip done");
        man <= 1'b0;
        wt(11, 0);
        nok <= 1'b0;
        wt(1, 1);
        chk("message", 0, o[14]);
        $display("test automatic transfer done");
        end_sim();
    end
endmodule // testbench
